// file: common/wdp_pkg.sv
// How it works
// - timer counts system clock cycles while enabled
// - seven-bit prescaler feeds a fourteen-bit counter
// - period select gives 2^(field+14) cycle time-out
// - time-out stretched by system prescaler plus one
// - any reset disables; power-down stops counting
// - unfed time-out raises an internal reset pulse
// - 1E then E1 starts timer, sets running
// - any write between the two bytes breaks sequence
// - wrong enable or feed sequence resets immediately
// - 5A then A5 soft-resets, sets soft flag
// - any other sequence resets, sets both flags
// - overflow flag sticky until software clears it
// - running flag read-only, cleared by any reset
// - control layout: period, idle, disable, flags, running
package wdp_pkg;
	localparam int unsigned ADDR_W        = 10;
	localparam int unsigned DATA_W        = 32;
	localparam int unsigned PRE_W_DEF     = 7;
	localparam int unsigned CNT_W_DEF     = 14;
	localparam int unsigned DIV_W_DEF     = 4;
	localparam int unsigned RST_PULSE_DEF = 4;

	// register indices; the byte address is four times the index
	localparam logic [7:0] SEQ_IDX      = 8'ha6;
	localparam logic [7:0] CTRL_IDX     = 8'ha7;
	localparam logic [7:0] IRQ_STAT_IDX = 8'ha8;
	localparam logic [7:0] IRQ_MASK_IDX = 8'ha9;

	localparam logic [7:0] KEY_ARM_1  = 8'h1e;
	localparam logic [7:0] KEY_ARM_2  = 8'he1;
	localparam logic [7:0] KEY_SOFT_1 = 8'h5a;
	localparam logic [7:0] KEY_SOFT_2 = 8'ha5;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] IRQ_RESET  = 3'h0;

	typedef struct packed {
		logic [2:0] period_select;
		logic       idle_pause_select;
		logic       reset_output_disable;
		logic       soft_reset_flag;
		logic       overflow_flag;
		logic       running_flag;
	} wdp_ctrl_t;

	typedef struct packed {
		logic soft_reset;
		logic bad_sequence;
		logic time_out;
	} wdp_evt_t;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_ARM  = 3'b010,
		SEQ_SOFT = 3'b100
	} wdp_seq_t;
endpackage

// file: core/wdp_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
module wdp_watchdog #(
	parameter int unsigned PRE_W         = wdp_pkg::PRE_W_DEF,
	parameter int unsigned CNT_W         = wdp_pkg::CNT_W_DEF,
	parameter int unsigned DIV_W         = wdp_pkg::DIV_W_DEF,
	parameter int unsigned RST_PULSE_CYC = wdp_pkg::RST_PULSE_DEF
) (
	input  wire logic                          clk_sys,
	input  wire logic                          resetn,
	input  wire logic [wdp_pkg::ADDR_W-1:0]    avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [wdp_pkg::DATA_W-1:0]    avs_writedata,
	output logic      [wdp_pkg::DATA_W-1:0]    avs_readdata,
	output logic                               avs_waitrequest,
	input  wire logic                          idle_mode,
	input  wire logic                          power_down,
	input  wire logic [DIV_W-1:0]              system_clock_prescaler,
	input  wire logic                          reset_polarity_pin,
	output logic                               wd_reset,
	output logic                               rst_pin_o,
	output logic                               rst_pin_oe,
	output logic                               irq
);
	import wdp_pkg::*;

	localparam int unsigned PULSE_W = $clog2(RST_PULSE_CYC + 1);
	localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(RST_PULSE_CYC);
	localparam logic [PULSE_W-1:0] PULSE_ONE  = PULSE_W'(1);

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		return addr == {idx, 2'b00};
	endfunction

	function automatic logic [PRE_W-1:0] pre_limit(input logic [2:0] ps);
		logic [PRE_W:0] span;
		span = (PRE_W + 1)'(1) << ps;
		return PRE_W'(span - 1'b1);
	endfunction

	logic [DATA_W-1:0]  avs_readdata_q;
	logic               waitrequest_q;
	wdp_ctrl_t          ctrl_q;
	wdp_seq_t           seq_q;
	wdp_seq_t           seq_d;
	logic [DIV_W-1:0]   div_q;
	logic [PRE_W-1:0]   pre_q;
	logic [CNT_W-1:0]   cnt_q;
	logic [PULSE_W-1:0] rst_cnt_q;
	logic               wd_reset_q;
	logic               wd_reset_d;
	logic               rst_pin_o_q;
	logic               rst_pin_oe_q;
	wdp_evt_t           stat_q;
	wdp_evt_t           stat_d;
	wdp_evt_t           mask_q;
	logic               irq_q;

	logic       wr_done;
	logic       rd_done;
	logic       rd_take;
	logic       seq_wr;
	logic       ctrl_wr;
	logic [7:0] wr_byte;
	logic       feed_ok;
	logic       soft_ok;
	logic       seq_bad;
	logic       count_en;
	logic       div_tick;
	logic       pre_carry;
	logic       timeout_evt;
	logic       rst_evt;

	assign avs_readdata    = avs_readdata_q;
	assign avs_waitrequest = waitrequest_q;
	assign wd_reset        = wd_reset_q;
	assign rst_pin_o       = rst_pin_o_q;
	assign rst_pin_oe      = rst_pin_oe_q;
	assign irq             = irq_q;

	// every access sees exactly one wait cycle; the action happens when it completes
	assign rd_take = avs_read && waitrequest_q;
	assign wr_done = avs_write && !waitrequest_q;
	assign rd_done = avs_read && !waitrequest_q;
	assign seq_wr  = wr_done && reg_hit(avs_address, SEQ_IDX);
	assign ctrl_wr = wr_done && reg_hit(avs_address, CTRL_IDX);
	assign wr_byte = avs_writedata[7:0];

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			waitrequest_q <= 1'b1;
		end else begin
			waitrequest_q <= !((avs_read || avs_write) && waitrequest_q);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			avs_readdata_q <= '0;
		end else if (rd_take) begin
			avs_readdata_q <= '0;
			if (reg_hit(avs_address, CTRL_IDX)) begin
				avs_readdata_q[7:0] <= ctrl_q;
			end else if (reg_hit(avs_address, IRQ_STAT_IDX)) begin
				avs_readdata_q[2:0] <= stat_q;
			end else if (reg_hit(avs_address, IRQ_MASK_IDX)) begin
				avs_readdata_q[2:0] <= mask_q;
			end
		end
	end

	// sequence checker; reads never disturb a half-written sequence
	always_comb begin
		seq_d   = seq_q;
		feed_ok = 1'b0;
		soft_ok = 1'b0;
		seq_bad = 1'b0;
		if (seq_wr) begin
			case (seq_q)
				SEQ_IDLE: begin
					if (wr_byte == KEY_ARM_1) begin
						seq_d = SEQ_ARM;
					end else if (wr_byte == KEY_SOFT_1) begin
						seq_d = SEQ_SOFT;
					end else begin
						seq_bad = 1'b1;
					end
				end
				SEQ_ARM: begin
					seq_d   = SEQ_IDLE;
					feed_ok = (wr_byte == KEY_ARM_2);
					seq_bad = (wr_byte != KEY_ARM_2);
				end
				SEQ_SOFT: begin
					seq_d   = SEQ_IDLE;
					soft_ok = (wr_byte == KEY_SOFT_2);
					seq_bad = (wr_byte != KEY_SOFT_2);
				end
				default: begin
					seq_d = SEQ_IDLE;
				end
			endcase
		end else if (wr_done && seq_q != SEQ_IDLE) begin
			seq_d   = SEQ_IDLE;
			seq_bad = 1'b1;
		end
		if (timeout_evt) begin
			seq_d = SEQ_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			seq_q <= SEQ_IDLE;
		end else begin
			seq_q <= seq_d;
		end
	end

	// counting chain: system prescaler, then 2^ps prescaler, then fixed counter
	assign count_en    = ctrl_q.running_flag && !power_down && !wd_reset_q
		&& !(idle_mode && ctrl_q.idle_pause_select);
	assign div_tick    = div_q >= system_clock_prescaler;
	assign pre_carry   = pre_q >= pre_limit(ctrl_q.period_select);
	assign timeout_evt = count_en && div_tick && pre_carry && (&cnt_q) && !feed_ok;
	assign rst_evt     = timeout_evt || seq_bad || soft_ok;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			div_q <= '0;
			pre_q <= '0;
			cnt_q <= '0;
		end else if (feed_ok || rst_evt) begin
			div_q <= '0;
			pre_q <= '0;
			cnt_q <= '0;
		end else if (count_en) begin
			if (div_tick) begin
				div_q <= '0;
				if (pre_carry) begin
					pre_q <= '0;
					cnt_q <= cnt_q + 1'b1;
				end else begin
					pre_q <= pre_q + 1'b1;
				end
			end else begin
				div_q <= div_q + 1'b1;
			end
		end
	end

	// flags: set wins over a software clear in the same cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= wdp_ctrl_t'(CTRL_RESET);
		end else begin
			if (ctrl_wr) begin
				ctrl_q.period_select        <= avs_writedata[7:5];
				ctrl_q.idle_pause_select    <= avs_writedata[4];
				ctrl_q.reset_output_disable <= avs_writedata[3];
				ctrl_q.soft_reset_flag      <= ctrl_q.soft_reset_flag && avs_writedata[2];
				ctrl_q.overflow_flag        <= ctrl_q.overflow_flag && avs_writedata[1];
			end
			if (feed_ok) begin
				ctrl_q.running_flag <= 1'b1;
			end
			if (rst_evt) begin
				ctrl_q.running_flag <= 1'b0;
			end
			if (soft_ok || seq_bad) begin
				ctrl_q.soft_reset_flag <= 1'b1;
			end
			if (seq_bad || timeout_evt) begin
				ctrl_q.overflow_flag <= 1'b1;
			end
		end
	end

	// a pulse rather than a single cycle so the rest of the chip sees a clean reset
	assign wd_reset_d = rst_evt || (rst_cnt_q > PULSE_ONE);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_cnt_q    <= '0;
			wd_reset_q   <= 1'b0;
			rst_pin_o_q  <= 1'b0;
			rst_pin_oe_q <= 1'b0;
		end else begin
			if (rst_evt) begin
				rst_cnt_q <= PULSE_LOAD;
			end else if (rst_cnt_q != '0) begin
				rst_cnt_q <= rst_cnt_q - PULSE_ONE;
			end
			wd_reset_q   <= wd_reset_d;
			rst_pin_o_q  <= reset_polarity_pin;
			rst_pin_oe_q <= wd_reset_d && !ctrl_q.reset_output_disable;
		end
	end

	always_comb begin
		stat_d = stat_q;
		if (rd_done && reg_hit(avs_address, IRQ_STAT_IDX)) begin
			// only bits the reader actually saw are cleared
			stat_d = stat_q & ~wdp_evt_t'(avs_readdata_q[2:0]);
		end
		stat_d.time_out     = stat_d.time_out || timeout_evt;
		stat_d.bad_sequence = stat_d.bad_sequence || seq_bad;
		stat_d.soft_reset   = stat_d.soft_reset || soft_ok;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stat_q <= wdp_evt_t'(IRQ_RESET);
			mask_q <= wdp_evt_t'(IRQ_RESET);
			irq_q  <= 1'b0;
		end else begin
			stat_q <= stat_d;
			if (wr_done && reg_hit(avs_address, IRQ_MASK_IDX)) begin
				mask_q <= wdp_evt_t'(avs_writedata[2:0]);
			end
			irq_q <= |(stat_d & mask_q);
		end
	end

	property p_enable;
		@(posedge clk_sys) disable iff (!resetn)
		feed_ok |=> ctrl_q.running_flag && cnt_q == '0 && pre_q == '0;
	endproperty
	a_enable: assert property (p_enable) else $error("enable sequence did not start timer");

	property p_feed_restart;
		@(posedge clk_sys) disable iff (!resetn)
		(feed_ok && ctrl_q.running_flag) |=> (div_q == '0 && pre_q == '0 && cnt_q == '0);
	endproperty
	a_feed_restart: assert property (p_feed_restart) else $error("feed did not restart count");

	property p_bad_seq;
		@(posedge clk_sys) disable iff (!resetn)
		seq_bad |=> wd_reset_q && ctrl_q.soft_reset_flag && ctrl_q.overflow_flag
			&& !ctrl_q.running_flag;
	endproperty
	a_bad_seq: assert property (p_bad_seq) else $error("bad sequence not handled");

	property p_split_write;
		@(posedge clk_sys) disable iff (!resetn)
		(seq_q == SEQ_ARM && wr_done && !seq_wr) |=> ctrl_q.overflow_flag && wd_reset_q;
	endproperty
	a_split_write: assert property (p_split_write) else $error("split write not caught");

	property p_soft;
		@(posedge clk_sys) disable iff (!resetn)
		soft_ok |=> wd_reset_q && ctrl_q.soft_reset_flag && $stable(ctrl_q.overflow_flag);
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset sequence mishandled");

	property p_timeout;
		@(posedge clk_sys) disable iff (!resetn)
		timeout_evt |=> wd_reset_q && ctrl_q.overflow_flag && !ctrl_q.running_flag;
	endproperty
	a_timeout: assert property (p_timeout) else $error("time-out did not reset");

	property p_pulse_len;
		@(posedge clk_sys) disable iff (!resetn)
		$rose(wd_reset_q) && !rst_evt |-> wd_reset_q [*4];
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too short");

	property p_stop;
		@(posedge clk_sys) disable iff (!resetn)
		(power_down || (idle_mode && ctrl_q.idle_pause_select)) && !rst_evt && !feed_ok
			|=> $stable(cnt_q) && $stable(pre_q);
	endproperty
	a_stop: assert property (p_stop) else $error("timer counted while paused");

	property p_pin;
		@(posedge clk_sys) disable iff (!resetn)
		$rose(wd_reset_q) && !$past(ctrl_q.reset_output_disable)
			|-> rst_pin_oe_q && rst_pin_o_q == $past(reset_polarity_pin);
	endproperty
	a_pin: assert property (p_pin) else $error("reset pin not driven");

	property p_ovf_sticky;
		@(posedge clk_sys) disable iff (!resetn)
		ctrl_q.overflow_flag && !ctrl_wr |=> ctrl_q.overflow_flag;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");

	// a control write must never touch the running bit
	property p_running_ro;
		@(posedge clk_sys) disable iff (!resetn)
		ctrl_wr && !rst_evt |=> ctrl_q.running_flag == $past(ctrl_q.running_flag);
	endproperty
	a_running_ro: assert property (p_running_ro) else $error("running flag changed by a write");

	property p_pin_quiet;
		@(posedge clk_sys) disable iff (!resetn)
		rst_pin_oe_q |-> wd_reset_q;
	endproperty
	a_pin_quiet: assert property (p_pin_quiet) else $error("reset pin driven outside pulse");

	// with the pause bit clear, idle must not freeze the chain
	property p_idle_count;
		@(posedge clk_sys) disable iff (!resetn)
		idle_mode && !ctrl_q.idle_pause_select && ctrl_q.running_flag && !power_down
			&& !wd_reset_q && !rst_evt && !feed_ok |=> !$stable({div_q, pre_q, cnt_q});
	endproperty
	a_idle_count: assert property (p_idle_count) else $error("timer stopped in idle");
endmodule
`default_nettype wire

// file: dv/tb_wdp_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
module tb_wdp_watchdog;
	import wdp_pkg::*;
	// shortened counter keeps every period the test waits out within a few hundred cycles
	localparam int CW = 4;
	typedef struct packed {
		logic [7:0]  idx;
		logic [7:0]  wd;
		logic [31:0] exp;
	} wdp_row_t;
	logic              clk_sys = 0;
	logic              resetn = 0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic              avs_read = 0;
	logic              avs_write = 0;
	logic [DATA_W-1:0] avs_writedata = '0;
	logic [DATA_W-1:0] avs_readdata;
	logic              avs_waitrequest;
	logic              idle_mode = 0;
	logic              power_down = 0;
	logic [3:0]        clk_div = '0;
	logic              rst_level = 1;
	logic              wd_reset;
	logic              rst_pin_o;
	logic              rst_pin_oe;
	logic              irq;
	int                num_errors = 0;
	int                checks_done = 0;
	int                cyc = 0;
	int                rst_cyc = 0;
	int                r0;
	int                n;
	int                per;
	logic [31:0]       q;
	wdp_row_t          rows [6] = '{'{CTRL_IDX, 8'hff, 32'hf8}, '{CTRL_IDX, 8'h5b, 32'h58},
		'{CTRL_IDX, 8'h00, 32'h0}, '{IRQ_MASK_IDX, 8'h07, 32'h7},
		'{IRQ_MASK_IDX, 8'h00, 32'h0}, '{8'hb0, 8'hff, 32'h0}};
	logic [15:0]       bad [4] = '{16'h1ee1, 16'h1e00, 16'h5a1e, 16'h33e1};

	wdp_watchdog #(.CNT_W(CW)) i_dut (
		.clk_sys                (clk_sys),
		.resetn                 (resetn),
		.avs_address            (avs_address),
		.avs_read               (avs_read),
		.avs_write              (avs_write),
		.avs_writedata          (avs_writedata),
		.avs_readdata           (avs_readdata),
		.avs_waitrequest        (avs_waitrequest),
		.idle_mode              (idle_mode),
		.power_down             (power_down),
		.system_clock_prescaler (clk_div),
		.reset_polarity_pin     (rst_level),
		.wd_reset               (wd_reset),
		.rst_pin_o              (rst_pin_o),
		.rst_pin_oe             (rst_pin_oe),
		.irq                    (irq)
	);

	always #5 clk_sys = ~clk_sys;

	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// pulse width is counted here so a short pulse is never missed between samples
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (wd_reset === 1'b1) rst_cyc <= rst_cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		q = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rd(input logic [7:0] idx);
		bus(1'b0, idx, 8'h00);
	endtask

	task automatic seq(input logic [7:0] a, input logic [7:0] b);
		wr(SEQ_IDX, a);
		wr(SEQ_IDX, b);
	endtask

	task automatic wait_rst();
		n = 0;
		while (wd_reset !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1;
		@(posedge clk_sys);
		rd(CTRL_IDX);
		chk(q, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd);
			rd(rows[i].idx);
			chk(q, rows[i].exp);
		end
		wr(IRQ_MASK_IDX, 8'h02);
		seq(KEY_SOFT_1, KEY_SOFT_2);
		wait_rst();
		chk(n < 8, 1);
		rd(CTRL_IDX);
		chk(q, 32'h04);
		chk(irq, 0);
		wr(CTRL_IDX, 8'h00);
		for (int ps = 0; ps < 4; ps++) begin
			clk_div <= 4'(ps);
			rst_level <= ps[0];
			wr(CTRL_IDX, {3'(ps), 1'b0, ps == 3, 3'b0});
			r0 = rst_cyc;
			seq(KEY_ARM_1, KEY_ARM_2);
			wait_rst();
			per = (ps + 1) << (ps + CW);
			chk(n >= per - 3 && n <= per + 3, 1);
			@(posedge clk_sys);
			chk(rst_pin_oe, ps != 3);
			chk(rst_pin_o, ps[0]);
			repeat (8) @(posedge clk_sys);
			chk(rst_cyc - r0, RST_PULSE_DEF);
			rd(CTRL_IDX);
			chk(q, {3'(ps), 1'b0, ps == 3, 3'b010});
			wr(CTRL_IDX, {3'(ps), 1'b0, ps == 3, 3'b0});
			rd(CTRL_IDX);
			chk(q[1], 0);
		end
		clk_div <= '0;
		wr(CTRL_IDX, 8'h20);
		seq(KEY_ARM_1, KEY_ARM_2);
		rd(CTRL_IDX);
		chk(q[0], 1);
		r0 = rst_cyc;
		repeat (4) begin
			repeat (18) @(posedge clk_sys);
			wr(SEQ_IDX, KEY_ARM_1);
			rd(CTRL_IDX);
			wr(SEQ_IDX, KEY_ARM_2);
		end
		chk(rst_cyc, r0);
		wait_rst();
		chk(n >= 29 && n <= 35, 1);
		repeat (6) @(posedge clk_sys);
		wr(CTRL_IDX, 8'h10);
		seq(KEY_ARM_1, KEY_ARM_2);
		r0 = rst_cyc;
		power_down <= 1;
		repeat (60) @(posedge clk_sys);
		power_down <= 0;
		idle_mode <= 1;
		repeat (60) @(posedge clk_sys);
		chk(rst_cyc, r0);
		wr(CTRL_IDX, 8'h00);
		wait_rst();
		chk(n <= 20, 1);
		idle_mode <= 0;
		clk_div <= 4'hf;
		wr(CTRL_IDX, 8'he0);
		seq(KEY_ARM_1, KEY_ARM_2);
		for (int i = 0; i < 4; i++) begin
			r0 = rst_cyc;
			wr(SEQ_IDX, bad[i][15:8]);
			if (i == 0) wr(CTRL_IDX, 8'he6);
			wr(SEQ_IDX, bad[i][7:0]);
			repeat (6) @(posedge clk_sys);
			chk(rst_cyc > r0, 1);
			rd(CTRL_IDX);
			chk(q, 32'he6);
			chk(irq, 1);
			rd(IRQ_STAT_IDX);
			chk(q[1], 1);
			@(posedge clk_sys);
			chk(irq, 0);
			wr(CTRL_IDX, 8'he0);
		end
		clk_div <= '0;
		seq(KEY_ARM_1, KEY_ARM_2);
		resetn <= 0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1;
		@(posedge clk_sys);
		rd(CTRL_IDX);
		chk(q, 32'h0);
		r0 = rst_cyc;
		repeat (100) @(posedge clk_sys);
		chk(rst_cyc, r0);
		conclude();
	end
endmodule
`default_nettype wire
